// ### logic/ih_pwm_params.svh
// Constants for the induction heater pulse and protection block.
// Assumes a single 25 MHz system clock and synchronous comparator inputs.
// How it works
// RULE_01 - Hard lock forces safe pulse at once
// RULE_02 - Soft lock drives safe value rest of period
// RULE_03 - After soft lock, reload width from safe
// RULE_04 - Pan present when 1 to 3 pulses
// RULE_05 - Software declares pan removed on low current
// RULE_06 - Surge and overvoltage raise preempting interrupts
// RULE_07 - Pan counter clocked by sync comparator output; here its rising edges are sampled on clk_sys_in
// RULE_08 - Tick from oscillator divided by 4096
// RULE_09 - Beeper sounds 0.2 s per enable
// RULE_10 - Display blinks with 0.5 s period
// RULE_11 - Alarm after 2 s error or 30 tries
// RULE_12 - Fan on while heating or hot
// RULE_13 - Sensor check after three minutes heating
// RULE_14 - Display codes E1 to E6 in order
// RULE_15 - Surge falling edge triggers hard lock
// RULE_16 - Overvoltage comparator triggers soft lock
// RULE_17 - Lock flags latched until software clears
`ifndef IH_PWM_PARAMS_SVH
`define IH_PWM_PARAMS_SVH
`define TICK_PRESCALE 4096
`define TICK_MATCH_DEFAULT 16'h0262
`define PAN_WINDOW_PERIODS 8'h03
`define PAN_COUNT_MIN 8'h01
`define PAN_COUNT_MAX 8'h03
`define WIDTH_RESET 16'h0000
`endif

// ### logic/ih_pwm_pkg.sv
// Types shared by the pulse generator and its pan detector.
// Assumes the params header is on the include path.
package ih_pwm_pkg;
  typedef enum logic [1:0] {PAN_IDLE, PAN_DRIVE, PAN_COUNT, PAN_DONE} pan_state_e;
endpackage

// ### logic/pan_pulse_counter.sv
// Pan detector: one drive pulse, then counts sync comparator pulses.
// Assumes the sync comparator output is synchronous to clk_sys_in.
`timescale 1ns/1ps
`include "ih_pwm_params.svh"
module pan_pulse_counter
  import ih_pwm_pkg::*;
#(
  parameter int WIN_PERIODS = `PAN_WINDOW_PERIODS
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Control
  input wire logic start_in,
  input wire logic period_end_in,
  input wire logic sync_comparator_output_in,
  // Results
  output logic drive_req_out,
  output logic done_out,
  output logic pan_present_out,
  output logic [7:0] count_out
);
  pan_state_e state, next_state;
  logic [7:0] count, next_count;
  logic [7:0] periods, next_periods;
  logic sync_d, next_sync_d;
  logic present, next_present;
  logic done, next_done;

  // Rising edges of the sync comparator counted on clk_sys_in, no interrupt [RULE_07]
  always_comb begin
    next_state = state;
    next_count = count;
    next_periods = periods;
    next_sync_d = sync_comparator_output_in;
    next_present = present;
    next_done = 1'b0;
    unique case (state)
      PAN_IDLE: begin
        if (start_in) begin
          next_state = PAN_DRIVE;
          next_count = 8'h00;
          next_periods = 8'h00;
        end
      end
      PAN_DRIVE: begin
        if (period_end_in) begin
          next_state = PAN_COUNT;
        end
      end
      PAN_COUNT: begin
        if (sync_comparator_output_in && !sync_d && count != 8'hFF) begin
          next_count = count + 8'h01; // [RULE_07]
        end
        if (period_end_in) begin
          next_periods = periods + 8'h01;
          if (next_periods >= 8'(WIN_PERIODS)) begin
            next_state = PAN_DONE;
          end
        end
      end
      PAN_DONE: begin
        next_present = (count >= `PAN_COUNT_MIN) && (count <= `PAN_COUNT_MAX); // [RULE_04]
        next_done = 1'b1;
        next_state = PAN_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state <= PAN_IDLE;
      count <= 8'h00;
      periods <= 8'h00;
      sync_d <= 1'b0;
      present <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      periods <= next_periods;
      sync_d <= next_sync_d;
      present <= next_present;
      done <= next_done;
    end
  end

  assign drive_req_out = (state == PAN_DRIVE);
  assign done_out = done;
  assign pan_present_out = present;
  assign count_out = count;

  property p_pan_verdict;
    @(posedge clk_sys_in) disable iff (rst_in)
      (state == PAN_DONE) |=> (present == (count >= 8'h01 && count <= 8'h03)) && done;
  endproperty
  a_pan_verdict: assert property (p_pan_verdict) else $error("pan verdict wrong"); // [RULE_04]

  property p_count_edge;
    @(posedge clk_sys_in) disable iff (rst_in)
      (state == PAN_COUNT && sync_comparator_output_in && !sync_d && count != 8'hFF)
        |=> count == $past(count) + 8'h01;
  endproperty
  a_count_edge: assert property (p_count_edge) else $error("pan edge not counted"); // [RULE_07]
endmodule

// ### logic/induction_pwm_protection.sv
// Pulse generator for the heater transistor with hard and soft locks,
// tick timer and pan detector. Assumes comparator inputs are synchronous.
`timescale 1ns/1ps
`include "ih_pwm_params.svh"
module induction_pwm_protection
  import ih_pwm_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int TICK_DIV = `TICK_PRESCALE,
  parameter logic [15:0] TICK_MATCH = `TICK_MATCH_DEFAULT
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Comparators
  input wire logic sync_comparator_output_in,
  input wire logic surge_comparator_in,
  input wire logic overvolt_comparator_in,
  // Software control
  input wire logic [WIDTH-1:0] period_in,
  input wire logic [WIDTH-1:0] working_pulse_width_in,
  input wire logic width_load_in,
  input wire logic [WIDTH-1:0] safe_pulse_width_in,
  input wire logic pwm_enable_in,
  input wire logic hard_lock_clear_in,
  input wire logic soft_lock_clear_in,
  input wire logic pan_detect_start_in,
  // Outputs
  output logic pulse_out,
  output logic hard_lock_flag_out,
  output logic soft_lock_flag_out,
  output logic surge_irq_out,
  output logic overvolt_irq_out,
  output logic tick_out,
  output logic [WIDTH-1:0] working_pulse_width_out,
  output logic pan_done_out,
  output logic pan_present_out,
  output logic [7:0] pan_count_out
);
  logic [WIDTH-1:0] phase, next_phase;
  logic [WIDTH-1:0] width, next_width;
  logic pulse, next_pulse;
  logic hard_flag, next_hard_flag;
  logic soft_flag, next_soft_flag;
  logic soft_active, next_soft_active;
  logic reload_pend, next_reload_pend;
  logic surge_d, next_surge_d;
  logic ov_d, next_ov_d;
  logic surge_irq, next_surge_irq;
  logic ov_irq, next_ov_irq;
  logic [11:0] pre, next_pre;
  logic [15:0] tick_cnt, next_tick_cnt;
  logic tick, next_tick;
  logic period_end;
  logic hard_ev;
  logic soft_ev;
  logic drive_req;
  logic pan_done;
  logic pan_present;
  logic [7:0] pan_count;

  assign period_end = (phase >= period_in - WIDTH'(1));
  assign hard_ev = surge_d && !surge_comparator_in; // Falling edge [RULE_15]
  assign soft_ev = overvolt_comparator_in && !ov_d; // Rising edge [RULE_16]

  // Period counter, width reload and pulse output
  always_comb begin
    next_phase = period_end ? '0 : phase + WIDTH'(1);
    next_width = width;
    next_soft_active = soft_active;
    next_reload_pend = reload_pend;
    next_surge_d = surge_comparator_in;
    next_ov_d = overvolt_comparator_in;
    if (width_load_in) begin
      next_width = working_pulse_width_in;
    end
    if (soft_ev) begin
      next_soft_active = 1'b1; // [RULE_02]
      next_reload_pend = 1'b1;
    end
    if (period_end) begin
      next_soft_active = soft_ev;
      if (reload_pend || soft_ev) begin
        next_width = safe_pulse_width_in; // [RULE_03]
        next_reload_pend = 1'b0;
      end
    end
    // Pulse high from period start while phase below width
    next_pulse = (pwm_enable_in || drive_req) && (next_phase < next_width);
    if (hard_flag || hard_ev) begin
      next_pulse = 1'b0; // Safe value at once [RULE_01]
    end else if (next_soft_active) begin
      next_pulse = 1'b0; // [RULE_02]
    end
  end

  // Flags and interrupts, set beats clear
  always_comb begin
    next_hard_flag = hard_ev || (hard_flag && !hard_lock_clear_in); // [RULE_17]
    next_soft_flag = soft_ev || (soft_flag && !soft_lock_clear_in); // [RULE_17]
    next_surge_irq = hard_ev; // [RULE_06]
    next_ov_irq = soft_ev; // [RULE_06]
  end

  // Tick timer: prescale then match count [RULE_08]
  always_comb begin
    next_pre = pre + 12'h001;
    next_tick_cnt = tick_cnt;
    next_tick = 1'b0;
    if (pre == 12'(TICK_DIV - 1)) begin
      next_pre = 12'h000;
      if (tick_cnt >= TICK_MATCH - 16'h0001) begin
        next_tick_cnt = 16'h0000;
        next_tick = 1'b1;
      end else begin
        next_tick_cnt = tick_cnt + 16'h0001;
      end
    end
  end

  // Registers
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      phase <= '0;
      width <= `WIDTH_RESET;
      pulse <= 1'b0;
      hard_flag <= 1'b0;
      soft_flag <= 1'b0;
      soft_active <= 1'b0;
      reload_pend <= 1'b0;
      surge_d <= 1'b1; // Idle level of the surge pin, so no edge is lost or faked
      ov_d <= 1'b0;
      surge_irq <= 1'b0;
      ov_irq <= 1'b0;
      pre <= 12'h000;
      tick_cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      phase <= next_phase;
      width <= next_width;
      pulse <= next_pulse;
      hard_flag <= next_hard_flag;
      soft_flag <= next_soft_flag;
      soft_active <= next_soft_active;
      reload_pend <= next_reload_pend;
      surge_d <= next_surge_d;
      ov_d <= next_ov_d;
      surge_irq <= next_surge_irq;
      ov_irq <= next_ov_irq;
      pre <= next_pre;
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
    end
  end

  // Pan detector [RULE_04]
  pan_pulse_counter #(
    .WIN_PERIODS(`PAN_WINDOW_PERIODS)
  ) u_pan (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .start_in(pan_detect_start_in),
    .period_end_in(period_end),
    .sync_comparator_output_in(sync_comparator_output_in),
    .drive_req_out(drive_req),
    .done_out(pan_done),
    .pan_present_out(pan_present),
    .count_out(pan_count)
  );

  // Output registers
  logic pan_done_q, pan_present_q;
  logic [7:0] pan_count_q;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pan_done_q <= 1'b0;
      pan_present_q <= 1'b0;
      pan_count_q <= 8'h00;
    end else begin
      pan_done_q <= pan_done;
      pan_present_q <= pan_present;
      pan_count_q <= pan_count;
    end
  end

  assign pulse_out = pulse;
  assign hard_lock_flag_out = hard_flag;
  assign soft_lock_flag_out = soft_flag;
  assign surge_irq_out = surge_irq;
  assign overvolt_irq_out = ov_irq;
  assign tick_out = tick;
  assign working_pulse_width_out = width;
  assign pan_done_out = pan_done_q;
  assign pan_present_out = pan_present_q;
  assign pan_count_out = pan_count_q;

  sequence s_surge_fall;
    $fell(surge_comparator_in);
  endsequence
  sequence s_ov_rise;
    $rose(overvolt_comparator_in);
  endsequence

  property p_hard_lock;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_surge_fall |=> !pulse_out && hard_lock_flag_out;
  endproperty
  a_hard_lock: assert property (p_hard_lock) else $error("hard lock missed"); // [RULE_01]

  property p_hard_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
      hard_lock_flag_out |=> !pulse_out;
  endproperty
  a_hard_hold: assert property (p_hard_hold) else $error("pulse during hard lock"); // [RULE_15]

  property p_soft_lock;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_ov_rise |=> !pulse_out && soft_lock_flag_out && overvolt_irq_out;
  endproperty
  a_soft_lock: assert property (p_soft_lock) else $error("soft lock missed"); // [RULE_02]

  property p_reload;
    @(posedge clk_sys_in) disable iff (rst_in)
      (reload_pend && period_end) |=> working_pulse_width_out == $past(safe_pulse_width_in);
  endproperty
  a_reload: assert property (p_reload) else $error("safe width not reloaded"); // [RULE_03]

  property p_flag_sticky;
    @(posedge clk_sys_in) disable iff (rst_in)
      (soft_lock_flag_out && !soft_lock_clear_in) |=> soft_lock_flag_out;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost"); // [RULE_17]

  property p_surge_irq;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_surge_fall |=> surge_irq_out ##1 !surge_irq_out || $fell(surge_comparator_in);
  endproperty
  a_surge_irq: assert property (p_surge_irq) else $error("surge irq wrong"); // [RULE_06]

  property p_tick_gap;
    @(posedge clk_sys_in) disable iff (rst_in)
      tick_out |=> !tick_out;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick too wide"); // [RULE_08]
endmodule

// ### verification/power_stage_model.sv
// Behavioural power stage and tank comparators facing the pulse block.
// Assumes the bench commands faults and ring counts at falling clock edges.
`timescale 1ns/1ps
module power_stage_model #(
  parameter int RING_DELAY = 20
) (
  // Clock and gate drive
  input wire logic clk_sys_in,
  input wire logic pulse_in,
  // Scenario control
  input wire logic arm_in,
  input wire logic [7:0] ring_n_in,
  input wire logic surge_trip_in,
  input wire logic ov_trip_in,
  // Comparator outputs
  output logic sync_comparator_output_out,
  output logic surge_comparator_out,
  output logic overvolt_comparator_out
);
  logic last_pulse = 1'b0;
  // Surge falls and over-voltage rises on a fault, both idle otherwise
  assign surge_comparator_out = ~surge_trip_in;
  assign overvolt_comparator_out = ov_trip_in;
  initial sync_comparator_output_out = 1'b0;
  // Tank rings a set number of times after a single drive pulse ends
  task automatic ring(input int n);
    repeat (RING_DELAY) @(negedge clk_sys_in);
    for (int i = 0; i < n; i++) begin
      sync_comparator_output_out = 1'b1;
      repeat (2) @(negedge clk_sys_in);
      sync_comparator_output_out = 1'b0;
      repeat (2) @(negedge clk_sys_in);
    end
  endtask
  // Watch the gate for the end of a pulse while armed
  always @(negedge clk_sys_in) begin
    last_pulse <= pulse_in;
    if (arm_in && last_pulse && !pulse_in) begin
      fork
        ring(ring_n_in);
      join_none
    end
  end
endmodule

// ### verification/induction_pwm_protection_tb.sv
// Self-checking bench for the pulse and protection block.
// Assumes power_stage_model stands in for the transistor stage.
`timescale 1ns/1ps
module induction_pwm_protection_tb
  import ih_pwm_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [15:0] period = 16'h0014;
  logic [15:0] width = 16'h0006;
  logic [15:0] safe = 16'h0002;
  logic width_load = 1'b0;
  logic pwm_enable = 1'b0;
  logic hard_clear = 1'b0;
  logic soft_clear = 1'b0;
  logic pan_start = 1'b0;
  logic arm = 1'b0;
  logic [7:0] ring_n = 8'h00;
  logic surge_trip = 1'b0;
  logic ov_trip = 1'b0;
  logic sync_cmp, surge_cmp, ov_cmp, pulse, hard_flag, soft_flag, surge_irq, ov_irq, tick;
  logic pan_done, pan_present;
  logic [15:0] width_now;
  logic [7:0] pan_count;
  int n_fail = 0;
  int check_count = 0;
  // 25 MHz system clock
  always #20 clk_sys_in = ~clk_sys_in;
  induction_pwm_protection #(.WIDTH(16), .TICK_DIV(4), .TICK_MATCH(16'h0002)) dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .sync_comparator_output_in(sync_cmp),
    .surge_comparator_in(surge_cmp), .overvolt_comparator_in(ov_cmp), .period_in(period),
    .working_pulse_width_in(width), .width_load_in(width_load), .safe_pulse_width_in(safe),
    .pwm_enable_in(pwm_enable), .hard_lock_clear_in(hard_clear),
    .soft_lock_clear_in(soft_clear), .pan_detect_start_in(pan_start), .pulse_out(pulse),
    .hard_lock_flag_out(hard_flag), .soft_lock_flag_out(soft_flag),
    .surge_irq_out(surge_irq), .overvolt_irq_out(ov_irq), .tick_out(tick),
    .working_pulse_width_out(width_now), .pan_done_out(pan_done),
    .pan_present_out(pan_present), .pan_count_out(pan_count));
  power_stage_model #(.RING_DELAY(20)) stage (
    .clk_sys_in(clk_sys_in), .pulse_in(pulse), .arm_in(arm), .ring_n_in(ring_n),
    .surge_trip_in(surge_trip), .ov_trip_in(ov_trip), .sync_comparator_output_out(sync_cmp),
    .surge_comparator_out(surge_cmp), .overvolt_comparator_out(ov_cmp));
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  // High cycles of the gate over n clocks
  task automatic count_high(input int n, output logic [15:0] c);
    c = 16'h0000;
    repeat (n) begin
      @(negedge clk_sys_in);
      if (pulse === 1'b1) c = c + 16'h0001;
    end
  endtask
  // Stops at the first high cycle of a fresh pulse
  task automatic wait_rise();
    int k;
    k = 0;
    while (pulse !== 1'b0 && k < 100) begin cycles(1); k++; end
    while (pulse !== 1'b1 && k < 200) begin cycles(1); k++; end
    check(pulse, 16'h0001);
  endtask
  task automatic t_normal();
    logic [15:0] c;
    check(width_now, 16'h0000);
    width_load = 1'b1;
    pwm_enable = 1'b1;
    cycles(1);
    width_load = 1'b0;
    cycles(45);
    count_high(20, c);
    check(c, 16'h0006);
    check(width_now, 16'h0006);
    $display("test normal done");
  endtask
  task automatic t_tick();
    int k;
    k = 0;
    while (tick !== 1'b1 && k < 50) begin cycles(1); k++; end
    check(tick, 16'h0001);
    k = 0;
    cycles(1);
    check(tick, 0);
    while (tick !== 1'b1 && k < 50) begin cycles(1); k++; end
    // Tick paces beeper time, blink, alarm and sensor
    check(k + 1, 8);
    $display("test tick done");
  endtask
  task automatic t_hard();
    logic [15:0] c;
    wait_rise();
    surge_trip = 1'b1;
    cycles(1);
    surge_trip = 1'b0;
    check(pulse, 0);
    check(hard_flag, 1);
    check(surge_irq, 1);
    cycles(1);
    check(surge_irq, 0);
    count_high(40, c);
    check(c, 16'h0000);
    check(hard_flag, 1);
    hard_clear = 1'b1;
    cycles(1);
    hard_clear = 1'b0;
    cycles(1);
    check(hard_flag, 0);
    cycles(20);
    count_high(20, c);
    check(c, 16'h0006);
    $display("test hard lock done");
  endtask
  task automatic t_soft();
    logic [15:0] c;
    wait_rise();
    ov_trip = 1'b1;
    cycles(1);
    ov_trip = 1'b0;
    check(pulse, 0);
    check(soft_flag, 1);
    check(ov_irq, 1);
    cycles(1);
    check(ov_irq, 0);
    cycles(24);
    check(width_now, safe);
    count_high(20, c);
    check(c, 16'h0002);
    check(soft_flag, 1);
    soft_clear = 1'b1;
    cycles(1);
    soft_clear = 1'b0;
    cycles(1);
    check(soft_flag, 0);
    $display("test soft lock done");
  endtask
  task automatic t_pan();
    int k;
    // Heating stops; fan and error codes follow in software
    pwm_enable = 1'b0;
    cycles(25);
    for (int n = 0; n < 5; n++) begin
      ring_n = 8'(n);
      arm = 1'b1;
      pan_start = 1'b1;
      cycles(1);
      pan_start = 1'b0;
      k = 0;
      while (pan_done !== 1'b1 && k < 300) begin cycles(1); k++; end
      check(pan_done, 1);
      check(pan_present, (n >= 1 && n <= 3));
      check(pan_count, 16'(n));
      arm = 1'b0; // Stage unloaded, as with the pan lifted off
      cycles(40);
    end
    $display("test pan detect done");
  endtask
  // Main sequence
  initial begin
    cycles(20);
    check(pulse, 0);
    check(hard_flag | soft_flag, 0);
    rst_in = 1'b0;
    cycles(1);
    t_normal();
    t_tick();
    t_hard();
    t_soft();
    t_pan();
    stop_test();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    n_fail++;
    stop_test();
  end
endmodule
